// ---- usbirq_regs.svh ----
// Register map, field positions, reset values and timing of the USB
// interrupt gate, frame capture and wakeup length block.
// Assumes a 250 MHz clock and a 32-bit classic Wishbone byte address.
`ifndef USBIRQ_REGS_SVH
`define USBIRQ_REGS_SVH

`define USBIRQ_ADR_PEND   32'h1520_0148
`define USBIRQ_ADR_GATE   32'h1520_014c
`define USBIRQ_ADR_FRAME  32'h1520_0150
`define USBIRQ_ADR_WLEN   32'h1520_0154
`define USBIRQ_ADR_CLR    32'h1520_0158

`define USBIRQ_GATE_W     10
`define USBIRQ_GATE_RST   10'h33f
`define USBIRQ_GATE_WMSK  10'h3bf
`define USBIRQ_GATE_CRC   9
`define USBIRQ_GATE_STUFF 8
`define USBIRQ_GATE_RST_B 7
`define USBIRQ_GATE_SUSP  5
`define USBIRQ_EP_W       5

`define USBIRQ_PEND_W     9
`define USBIRQ_PEND_ERR   8
`define USBIRQ_PEND_BRST  7
`define USBIRQ_PEND_RES   6
`define USBIRQ_PEND_SUSP  5

`define USBIRQ_FRAME_W    11
`define USBIRQ_FRAME_RST  11'h000
`define USBIRQ_WLEN_W     5
`define USBIRQ_WLEN_RST   5'h0a

`define USBIRQ_CLK_MHZ    250
`define USBIRQ_MS_US      1000
`define USBIRQ_IDLE_US    3000

`endif

// ---- usbirq_pkg.sv ----
// Types shared by the USB interrupt gate block and its bench.
// Field widths follow the register header.
package usbirq_pkg;

  // Event inputs from the USB protocol engine
  typedef struct packed {
    logic [4:0] ep;
    logic       bus_reset;
    logic       crc_err;
    logic       stuff_err;
    logic       resume_rx;
    logic       bus_idle;
  } usbirq_evt_t;

  // Start-Of-Frame capture strobe with its frame number
  typedef struct packed {
    logic        valid;
    logic [10:0] frame;
  } usbirq_sof_t;

  typedef enum logic [1:0] {
    RS_IDLE,
    RS_DRIVE,
    RS_HOLD
  } usbirq_rs_t;

endpackage : usbirq_pkg

// ---- usbirq_top.sv ----
// USB device interrupt gating, SOF frame capture, wakeup signal timing.
// Assumes a Wishbone classic master, one 250 MHz clock, and event inputs
// synchronous to that clock from the USB protocol engine.
//
// Overview of operation
// - A masked source never reaches the processor while masked, except a pending error while one of CRC and stuff is unmasked.
// - Resume interrupt always reaches the processor; no mask bit exists.
// - Mask bit 0 enables, 1 masks; reset leaves only bus reset unmasked.
// - CRC error mask bit 9, bit-stuff mask bit 8, both masked at reset.
// - Bus reset mask at bit 7, clear after reset.
// - Suspend mask at bit 5, set after reset.
// - Endpoint 4..0 masks at bits 4..0, all set after reset.
// - Each SOF loads its 11-bit frame number into a read-only field.
// - Wakeup signal length timed by 5-bit down counter from length field.
// - Length field bits 4..0 counts milliseconds; N gives N ms.
// - Wakeup length resets to ten milliseconds.
// - In suspend with resume request set, drive wakeup for programmed length.
// - Suspend pending set every 3 ms while the bus stays idle.
// - One error pending flag, set by CRC or stuff error, each own mask.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "usbirq_regs.svh"

module usbirq_top #(
  parameter int MS_CYC   = `USBIRQ_MS_US * `USBIRQ_CLK_MHZ,
  parameter int IDLE_CYC = `USBIRQ_IDLE_US * `USBIRQ_CLK_MHZ
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [31:0]           adr_i,
  input  wire logic [31:0]           dat_i,
  input  wire logic [3:0]            sel_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  input  wire usbirq_pkg::usbirq_evt_t evt_i,
  input  wire usbirq_pkg::usbirq_sof_t sof_i,
  input  wire logic                  suspend_mode_i,
  input  wire logic                  resume_req_i,
  output logic                       resume_drive_o,
  output logic                       irq_o
);

  localparam int MW = $clog2(MS_CYC + 1);
  localparam int IW = $clog2(IDLE_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // Byte-lane merge, used by all three writable registers: mask, length and clear
  function automatic logic [31:0] usbirq_lane(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : usbirq_lane

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [`USBIRQ_GATE_W-1:0]  gate_q;
  logic [`USBIRQ_GATE_W-1:0]  gate_d;
  logic [`USBIRQ_FRAME_W-1:0] frame_q;
  logic [`USBIRQ_WLEN_W-1:0]  wlen_q;
  logic [`USBIRQ_WLEN_W-1:0]  wlen_d;
  logic [`USBIRQ_PEND_W-1:0]  pend_q;
  logic [`USBIRQ_PEND_W-1:0]  pend_d;
  logic                       ack_q;
  logic [31:0]                dat_q;
  logic                       irq_q;
  logic                       resume_q;
  logic [IW-1:0]              idle_cnt_q;
  logic [MW-1:0]              ms_cnt_q;
  logic [`USBIRQ_WLEN_W-1:0]  down_q;
  logic [`USBIRQ_WLEN_W-1:0]  down_d;
  usbirq_pkg::usbirq_rs_t     rs_q;
  usbirq_pkg::usbirq_rs_t     rs_d;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone decode
  wire        req      = cyc_i & stb_i & ~ack_q;
  wire        wr       = req & we_i;
  wire        hit_pend = adr_i == `USBIRQ_ADR_PEND;
  wire        hit_gate = adr_i == `USBIRQ_ADR_GATE;
  wire        hit_frm  = adr_i == `USBIRQ_ADR_FRAME;
  wire        hit_wlen = adr_i == `USBIRQ_ADR_WLEN;
  wire        hit_clr  = adr_i == `USBIRQ_ADR_CLR;
  wire [31:0] gate_x   = {{(32-`USBIRQ_GATE_W){1'b0}}, gate_q};
  wire [31:0] wlen_x   = {{(32-`USBIRQ_WLEN_W){1'b0}}, wlen_q};
  wire [31:0] gate_m   = usbirq_lane(gate_x, dat_i, sel_i);
  wire [31:0] wlen_m   = usbirq_lane(wlen_x, dat_i, sel_i);
  wire [31:0] clr_m    = usbirq_lane(32'h0, dat_i, sel_i);

  // Unmapped and write-only addresses read as zero
  wire [31:0] rd_data =
    hit_pend ? {{(32-`USBIRQ_PEND_W){1'b0}}, pend_q} :
    hit_gate ? gate_x :
    hit_frm  ? {{(32-`USBIRQ_FRAME_W){1'b0}}, frame_q} :
    hit_wlen ? wlen_x : 32'h0;

  // Reserved bits never stored
  assign gate_d = (wr & hit_gate) ?
                  gate_m[`USBIRQ_GATE_W-1:0] & `USBIRQ_GATE_WMSK : gate_q;
  assign wlen_d = (wr & hit_wlen) ? wlen_m[`USBIRQ_WLEN_W-1:0] : wlen_q;

  ////////////////////////////////////////////////////////////////////////
  // Event decode into pending bits
  wire idle_tick = evt_i.bus_idle & (idle_cnt_q == IW'(IDLE_CYC - 1));
  wire err_set   = (evt_i.crc_err & ~gate_q[`USBIRQ_GATE_CRC]) |
                   (evt_i.stuff_err & ~gate_q[`USBIRQ_GATE_STUFF]);

  wire [`USBIRQ_PEND_W-1:0] pend_set = {
    err_set,
    evt_i.bus_reset,
    evt_i.resume_rx,
    idle_tick,
    evt_i.ep
  };

  wire [`USBIRQ_PEND_W-1:0] pend_clr =
    (wr & hit_clr) ? clr_m[`USBIRQ_PEND_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  assign pend_d = (pend_q & ~pend_clr) | pend_set;

  // Per-bit enables; resume has no mask position
  wire [`USBIRQ_PEND_W-1:0] pend_en = {
    ~(gate_q[`USBIRQ_GATE_CRC] & gate_q[`USBIRQ_GATE_STUFF]),
    ~gate_q[`USBIRQ_GATE_RST_B],
    1'b1,
    ~gate_q[`USBIRQ_GATE_SUSP],
    ~gate_q[`USBIRQ_EP_W-1:0]
  };

  wire irq_d = |(pend_q & pend_en);

  ////////////////////////////////////////////////////////////////////////
  // Wakeup signal timing
  wire ms_tick = ms_cnt_q == MW'(MS_CYC - 1);
  wire wake_go = suspend_mode_i & resume_req_i;

  always_comb begin
    rs_d   = rs_q;
    down_d = down_q;
    unique case (rs_q)
      usbirq_pkg::RS_IDLE: begin
        if (wake_go) begin
          down_d = wlen_q;
          rs_d   = (wlen_q == '0) ? usbirq_pkg::RS_HOLD : usbirq_pkg::RS_DRIVE;
        end
      end
      usbirq_pkg::RS_DRIVE: begin
        if (ms_tick) begin
          down_d = down_q - 1'b1;
          if (down_q == `USBIRQ_WLEN_W'(1)) begin
            rs_d = usbirq_pkg::RS_HOLD;
          end
        end
      end
      usbirq_pkg::RS_HOLD: begin
        // Waits for the request to drop so one request gives one wakeup
        if (!wake_go) begin
          rs_d = usbirq_pkg::RS_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_q <= `USBIRQ_GATE_RST;
      wlen_q <= `USBIRQ_WLEN_RST;
      pend_q <= '0;
    end else begin
      gate_q <= gate_d;
      wlen_q <= wlen_d;
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_q <= `USBIRQ_FRAME_RST;
    end else if (sof_i.valid) begin
      frame_q <= sof_i.frame;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req;
      dat_q <= req ? rd_data : 32'h0;
    end
  end

  // Restarts each 3 ms period, so idle keeps raising suspend
  always_ff @(posedge clk_i) begin
    if (rst_i || !evt_i.bus_idle || idle_tick) begin
      idle_cnt_q <= '0;
    end else begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rs_q != usbirq_pkg::RS_DRIVE || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs_q     <= usbirq_pkg::RS_IDLE;
      down_q   <= '0;
      resume_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      rs_q     <= rs_d;
      down_q   <= down_d;
      resume_q <= rs_d == usbirq_pkg::RS_DRIVE;
      irq_q    <= irq_d;
    end
  end

  assign ack_o          = ack_q;
  assign dat_o          = dat_q;
  assign irq_o          = irq_q;
  assign resume_drive_o = resume_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_gate_rst;
    $fell(rst_i) |-> gate_q == `USBIRQ_GATE_RST && wlen_q == `USBIRQ_WLEN_RST;
  endproperty
  a_gate_rst: assert property (p_gate_rst)
    else $error("mask or length reset value wrong");

  property p_masked_quiet;
    irq_o |-> $past(|(pend_q & pend_en));
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt raised with no enabled pending bit");

  property p_resume_irq;
    pend_q[`USBIRQ_PEND_RES] ##1 pend_q[`USBIRQ_PEND_RES] |-> irq_o;
  endproperty
  a_resume_irq: assert property (p_resume_irq)
    else $error("resume pending did not raise interrupt");

  property p_frame;
    sof_i.valid |=> frame_q == $past(sof_i.frame);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame number not captured");

  property p_err_set;
    evt_i.crc_err && !gate_q[`USBIRQ_GATE_CRC] |=> pend_q[`USBIRQ_PEND_ERR];
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("unmasked crc error did not set error pending");

  property p_err_masked;
    !pend_q[`USBIRQ_PEND_ERR] && evt_i.crc_err && !evt_i.stuff_err &&
      gate_q[`USBIRQ_GATE_CRC] |=> !pend_q[`USBIRQ_PEND_ERR];
  endproperty
  a_err_masked: assert property (p_err_masked)
    else $error("masked crc error set error pending");

  property p_susp_tick;
    idle_tick |=> pend_q[`USBIRQ_PEND_SUSP];
  endproperty
  a_susp_tick: assert property (p_susp_tick)
    else $error("idle period did not set suspend pending");

  property p_wake_load;
    $rose(resume_drive_o) |-> down_q == $past(wlen_q) && down_q != '0;
  endproperty
  a_wake_load: assert property (p_wake_load)
    else $error("wakeup counter not loaded from length");

  property p_wake_start;
    rs_q == usbirq_pkg::RS_IDLE && wake_go && wlen_q != '0 |=> resume_drive_o;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("wakeup drive did not start");

  property p_wake_end;
    resume_drive_o && ms_tick && down_q == `USBIRQ_WLEN_W'(1) |=> !resume_drive_o;
  endproperty
  a_wake_end: assert property (p_wake_end)
    else $error("wakeup drive did not end at count one");

  property p_stuff_masked;
    !pend_q[`USBIRQ_PEND_ERR] && evt_i.stuff_err && !evt_i.crc_err &&
      gate_q[`USBIRQ_GATE_STUFF] |=> !pend_q[`USBIRQ_PEND_ERR];
  endproperty
  a_stuff_masked: assert property (p_stuff_masked)
    else $error("masked bit-stuff error set error pending");

  property p_stuff_set;
    evt_i.stuff_err && !gate_q[`USBIRQ_GATE_STUFF] |=> pend_q[`USBIRQ_PEND_ERR];
  endproperty
  a_stuff_set: assert property (p_stuff_set)
    else $error("unmasked bit-stuff error did not set error pending");

  // Irq follows the enabled pending bits one cycle later
  property p_irq_on;
    |(pend_q & pend_en) |=> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled pending bit did not raise interrupt");

  property p_irq_off;
    !(|(pend_q & pend_en)) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt high with every pending bit masked");

  property p_frame_hold;
    !sof_i.valid |=> $stable(frame_q);
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("frame number changed without a frame strobe");

  property p_gate_rsv;
    (gate_q & ~`USBIRQ_GATE_WMSK) == '0;
  endproperty
  a_gate_rsv: assert property (p_gate_rsv)
    else $error("reserved mask bit holds a one");

  property p_hold_quiet;
    rs_q == usbirq_pkg::RS_HOLD |-> !resume_drive_o;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet)
    else $error("wakeup still driven after its length ran out");

endmodule : usbirq_top

// ---- usbirq_host_model.sv ----
// Far-side stand-in for the USB host: event pulses, bus idle, SOF strobes.
// Assumes its tasks are called right after a rising edge of clk_i.
`timescale 1ns/10ps

module usbirq_host_model (
  input  wire logic               clk_i,
  output usbirq_pkg::usbirq_evt_t evt_o,
  output usbirq_pkg::usbirq_sof_t sof_o
);

  initial begin
    evt_o = '0;
    sof_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic pulse(input usbirq_pkg::usbirq_evt_t e);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= '0;
  endtask : pulse

  // Frame lines invert once the strobe drops, so stale data never matches
  task automatic sof(input logic [10:0] f);
    sof_o <= {1'b1, f};
    @(posedge clk_i);
    sof_o <= {1'b0, ~f};
  endtask : sof

  task automatic idle(input int n);
    evt_o.bus_idle <= 1'b1;
    repeat (n) @(posedge clk_i);
    evt_o.bus_idle <= 1'b0;
  endtask : idle

endmodule : usbirq_host_model

// ---- test_usbirq_top.sv ----
// Self-checking bench for the interrupt gate, frame capture and wakeup timer.
// Assumes short counts MS_CYC=8, IDLE_CYC=20 and a classic Wishbone slave.
`timescale 1ns/10ps
`include "usbirq_regs.svh"

module test_usbirq_top;
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    cyc_i = 1'b0;
  logic                    stb_i = 1'b0;
  logic                    we_i  = 1'b0;
  logic [31:0]             adr_i = 32'h0000_0000;
  logic [31:0]             dat_i = 32'h0000_0000;
  logic [3:0]              sel_i = 4'hf;
  logic [31:0]             dat_o;
  logic                    ack_o;
  logic                    suspend_mode_i = 1'b0;
  logic                    resume_req_i   = 1'b0;
  logic                    resume_drive_o;
  logic                    irq_o;
  logic [31:0]             rd;
  usbirq_pkg::usbirq_evt_t evt;
  usbirq_pkg::usbirq_sof_t sof;
  int                      failures = 0;
  int                      compares = 0;

  always #2 clk_i = ~clk_i;

  usbirq_host_model host (.clk_i(clk_i), .evt_o(evt), .sof_o(sof));

  usbirq_top #(.MS_CYC(8), .IDLE_CYC(20)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .evt_i(evt), .sof_i(sof), .suspend_mode_i(suspend_mode_i),
    .resume_req_i(resume_req_i), .resume_drive_o(resume_drive_o), .irq_o(irq_o));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Request held until ack is sampled high; data taken at that edge
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic test_done;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    wb(0, `USBIRQ_ADR_GATE, 0);  chk(rd, 32'h0000_033f);
    wb(0, `USBIRQ_ADR_FRAME, 0); chk(rd, 32'h0000_0000);
    wb(0, `USBIRQ_ADR_WLEN, 0);  chk(rd, 32'h0000_000a);
    wb(0, 32'h1520_015c, 0);     chk(rd, 32'h0000_0000);
    wb(1, `USBIRQ_ADR_GATE, 32'hffff_ffff);
    wb(0, `USBIRQ_ADR_GATE, 0);  chk(rd, 32'h0000_03bf);
  endtask : t_reset

  // Source pulse, then irq and pending checked before the clear, irq again after
  task automatic t_src(input logic [9:0] e, input logic [31:0] gate, input logic [31:0] pend,
                       input logic exp_irq);
    wb(1, `USBIRQ_ADR_GATE, gate);
    host.pulse(e);
    repeat (3) @(posedge clk_i);
    chk(irq_o, exp_irq);
    wb(0, `USBIRQ_ADR_PEND, 0); chk(rd, pend);
    wb(1, `USBIRQ_ADR_CLR, 32'h0000_01ff);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
  endtask : t_src

  task automatic t_sof(input logic [10:0] f);
    host.sof(f);
    wb(1, `USBIRQ_ADR_FRAME, 32'h0000_0000);
    wb(0, `USBIRQ_ADR_FRAME, 0); chk(rd, {21'h0, f});
  endtask : t_sof

  task automatic t_susp;
    wb(1, `USBIRQ_ADR_GATE, 32'h0000_03df);
    fork
      host.idle(46);
      begin
        repeat (23) @(posedge clk_i);
        chk(irq_o, 1'b1);
        wb(0, `USBIRQ_ADR_PEND, 0); chk(rd, 32'h0000_0020);
        wb(1, `USBIRQ_ADR_CLR, 32'h0000_0020);
        wb(0, `USBIRQ_ADR_PEND, 0); chk(rd, 32'h0000_0000);
        repeat (12) @(posedge clk_i);
        wb(0, `USBIRQ_ADR_PEND, 0); chk(rd, 32'h0000_0020);
      end
    join
    wb(1, `USBIRQ_ADR_CLR, 32'h0000_01ff);
  endtask : t_susp

  // Drive length counted in cycles: N ms at 8 cycles each
  task automatic t_wake(input logic [4:0] n, input logic wr);
    int cnt;
    cnt = 0;
    if (wr) wb(1, `USBIRQ_ADR_WLEN, {27'h7ff_ffff, n});
    suspend_mode_i <= 1'b1;
    resume_req_i   <= 1'b1;
    repeat (300) begin
      @(posedge clk_i);
      if (resume_drive_o === 1'b1) cnt++;
    end
    chk(32'(cnt), 32'(n) * 32'd8);
    suspend_mode_i <= 1'b0;
    resume_req_i   <= 1'b0;
    @(posedge clk_i);
  endtask : t_wake

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_src(10'h020, 32'h0000_03ff, 32'h0000_0001, 1'b0);
    t_src(10'h020, 32'h0000_03fe, 32'h0000_0001, 1'b1);
    t_src(10'h010, 32'h0000_033f, 32'h0000_0080, 1'b1);
    t_src(10'h002, 32'h0000_03ff, 32'h0000_0040, 1'b1);
    t_src(10'h004, 32'h0000_01ff, 32'h0000_0000, 1'b0);
    t_src(10'h008, 32'h0000_01ff, 32'h0000_0100, 1'b1);
    t_src(10'h008, 32'h0000_02ff, 32'h0000_0000, 1'b0);
    t_src(10'h004, 32'h0000_02ff, 32'h0000_0100, 1'b1);
    t_sof(11'h5a5);
    t_sof(11'h7ff);
    t_susp;
    t_wake(5'h0a, 1'b0);
    t_wake(5'h03, 1'b1);
    t_wake(5'h1f, 1'b1);
    test_done;
  end

  // Whole run is about 1100 cycles
  initial begin
    #80000;
    failures++;
    test_done;
  end

endmodule : test_usbirq_top
